// File: tmcps_defines.vh
`ifndef TMCPS_DEFINES_VH
`define TMCPS_DEFINES_VH

`define TMCPS_MST_AW 24
`define TMCPS_PIN_AW 23
`define TMCPS_PIN_DW 32
`define TMCPS_FL_AW 23
`define TMCPS_FL_DW 16
`define TMCPS_SR_AW 21
`define TMCPS_SR_DW 32
`define TMCPS_SR_BASE 24'h800000
`define TMCPS_MAP_END 24'hA00000
`define TMCPS_BRIDGE_LAT 2

`define TMCPS_CLK_NS 20
`define TMCPS_FL_RD_NS 100
`define TMCPS_FL_WR_NS 80
`define TMCPS_FL_TA_NS 40
`define TMCPS_FL_HOLD_NS 20
`define TMCPS_SR_RD_NS 20
`define TMCPS_SR_WR_NS 20
`define TMCPS_SR_TA_NS 20
`define TMCPS_SR_HOLD_NS 20
`define TMCPS_CYC(ns) (((ns) + `TMCPS_CLK_NS - 1) / `TMCPS_CLK_NS)

`endif

// File: tmcps_gen_ctl.v
`timescale 1ns/1ns
`include "tmcps_defines.vh"
module tmcps_gen_ctl #(
   parameter AW = 23,
   parameter DW = 16,
   parameter RD_WAIT = 5,
   parameter WR_WAIT = 4,
   parameter TURN = 2,
   parameter HOLD = 1,
   parameter LAT = `TMCPS_BRIDGE_LAT
)(
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire [AW-1:0] s_addr_i,
   input wire s_read_i,
   input wire s_write_i,
   input wire [DW-1:0] s_wdata_i,
   output wire s_waitreq_o,
   output wire [DW-1:0] s_rdata_o,
   output wire c_req_o,
   input wire c_grant_i,
   output wire [AW-1:0] c_addr_o,
   output wire [DW-1:0] c_wdata_o,
   output wire c_drive_o,
   output wire c_rd_o,
   output wire c_we_o,
   output wire c_cs_o,
   input wire [DW-1:0] c_rdata_i
);
   function integer fmax;
      input integer a;
      input integer b;
      begin
         fmax = (a > b) ? a : b;
      end
   endfunction

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_REQ = 3'h1;
   localparam [2:0] ST_ACT = 3'h2;
   localparam [2:0] ST_LAT = 3'h3;
   localparam [2:0] ST_HLD = 3'h4;
   localparam [2:0] ST_DONE = 3'h5;
   localparam integer RD_E = RD_WAIT - 1;
   localparam integer WR_E = WR_WAIT - 1;
   localparam integer LAT_E = LAT - 1;
   localparam integer HOLD_E = HOLD - 1;
   localparam integer TEFF_E = fmax(TURN, RD_WAIT + LAT) - 1;
   localparam [7:0] RD_END = RD_E[7:0];
   localparam [7:0] WR_END = WR_E[7:0];
   localparam [7:0] LAT_END = LAT_E[7:0];
   localparam [7:0] HOLD_END = HOLD_E[7:0];
   localparam [7:0] TEFF_END = TEFF_E[7:0];

   reg [2:0] state_q;
   reg [7:0] cnt_q;
   reg [7:0] since_q;
   reg is_rd_q;
   reg [AW-1:0] addr_q;
   reg [DW-1:0] wdata_q;
   reg [DW-1:0] rdata_q;
   wire done_w;

   assign done_w = (state_q == ST_DONE) && (since_q >= TEFF_END);
   assign s_waitreq_o = ~done_w;
   assign s_rdata_o = rdata_q;
   assign c_req_o = (state_q != ST_IDLE);
   assign c_addr_o = addr_q;
   assign c_wdata_o = wdata_q;
   assign c_cs_o = (state_q == ST_ACT) || (state_q == ST_LAT) ||
                   (state_q == ST_HLD);
   assign c_rd_o = is_rd_q && ((state_q == ST_ACT) || (state_q == ST_LAT));
   assign c_we_o = ~is_rd_q && (state_q == ST_ACT);
   assign c_drive_o = ~is_rd_q && ((state_q == ST_ACT) ||
                      (state_q == ST_HLD));

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
         since_q <= 8'h00;
         is_rd_q <= 1'b0;
         addr_q <= {AW{1'b0}};
         wdata_q <= {DW{1'b0}};
         rdata_q <= {DW{1'b0}};
      end
      else
      begin
         if (state_q != ST_IDLE && since_q != 8'hFF)
            since_q <= since_q + 8'h01;
         case (state_q)
            ST_IDLE:
               if (s_read_i || s_write_i)
               begin
                  is_rd_q <= s_read_i;
                  addr_q <= s_addr_i;
                  wdata_q <= s_wdata_i;
                  since_q <= 8'h00;
                  state_q <= ST_REQ;
               end
            ST_REQ:
               if (c_grant_i)
               begin
                  cnt_q <= 8'h00;
                  state_q <= ST_ACT;
               end
            ST_ACT:
            begin
               cnt_q <= cnt_q + 8'h01;
               if (is_rd_q && cnt_q >= RD_END)
               begin
                  cnt_q <= 8'h00;
                  state_q <= ST_LAT;
               end
               else if (!is_rd_q && cnt_q >= WR_END)
               begin
                  cnt_q <= 8'h00;
                  state_q <= (HOLD > 0) ? ST_HLD : ST_DONE;
               end
            end
            ST_LAT:
            begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q >= LAT_END)
               begin
                  rdata_q <= c_rdata_i;
                  state_q <= ST_DONE;
               end
            end
            ST_HLD:
            begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q >= HOLD_END)
                  state_q <= ST_DONE;
            end
            ST_DONE:
               if (done_w)
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // tmcps_gen_ctl

// File: tmcps_top.v
`timescale 1ns/1ns
`include "tmcps_defines.vh"
module tmcps_top #(
   parameter MAW = `TMCPS_MST_AW,
   parameter PAW = `TMCPS_PIN_AW,
   parameter PDW = `TMCPS_PIN_DW
)(
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire [MAW-1:0] mst_addr_i,
   input wire mst_read_i,
   input wire mst_write_i,
   input wire [PDW-1:0] mst_wdata_i,
   output wire mst_waitreq_o,
   output wire [PDW-1:0] mst_rdata_o,
   output wire mst_err_o,
   output wire [PAW-1:0] pin_addr_o,
   output wire pin_ctl_oe_n_o,
   output wire [PDW-1:0] pin_data_o,
   output wire pin_data_oe_n_o,
   input wire [PDW-1:0] pin_data_i,
   output wire pin_rd_n_o,
   output wire pin_we_n_o,
   output wire pin_fl_cs_n_o,
   output wire pin_sr_cs_n_o
);
   // Per-memory widths and map bounds
   localparam FAW = `TMCPS_FL_AW;
   localparam FDW = `TMCPS_FL_DW;
   localparam SAW = `TMCPS_SR_AW;
   localparam SDW = `TMCPS_SR_DW;
   localparam [MAW-1:0] SR_BASE = `TMCPS_SR_BASE;
   localparam [MAW-1:0] MAP_END = `TMCPS_MAP_END;

   // Controller-side and pad-side nets
   wire sel_fl;
   wire sel_sr;
   wire [MAW-1:0] sr_off;
   wire fl_wait, sr_wait, fl_req, sr_req;
   wire fl_drv, sr_drv, fl_rd, sr_rd, fl_we, sr_we, fl_cs, sr_cs;
   wire [FAW-1:0] fl_addr;
   wire [SAW-1:0] sr_addr;
   wire [FDW-1:0] fl_wdata, fl_rdata;
   wire [SDW-1:0] sr_wdata, sr_rdata;
   wire [PAW-1:0] fl_addr_x, sr_addr_x;
   wire [PDW-1:0] fl_wdata_x, sr_wdata_x;
   reg [1:0] own_q;
   reg [1:0] own_d;
   reg last_sr_q;
   reg [PAW-1:0] addr_q;
   reg [PDW-1:0] wdata_q;
   reg [PDW-1:0] rdata_q;
   reg drv_q, rd_q, we_q, fl_cs_q, sr_cs_q, ctl_oe_n_q;

   // Address map: flash below SRAM base, SRAM up to map end
   assign sel_fl = (mst_addr_i < SR_BASE);
   assign sel_sr = ~sel_fl && (mst_addr_i < MAP_END);
   assign sr_off = mst_addr_i - SR_BASE;
   // Unmapped: error answer, no stall
   assign mst_err_o = (mst_read_i || mst_write_i) && ~sel_fl && ~sel_sr;
   // Stall and read data steered by address
   assign mst_waitreq_o = sel_fl ? fl_wait : (sel_sr ? sr_wait : 1'b0);
   assign mst_rdata_o = sel_fl ? {{(PDW-FDW){1'b0}}, fl_rdata} : sr_rdata;

   // Flash controller, 16-bit words
   tmcps_gen_ctl #(
      .AW(FAW),
      .DW(FDW),
      .RD_WAIT(`TMCPS_CYC(`TMCPS_FL_RD_NS)),
      .WR_WAIT(`TMCPS_CYC(`TMCPS_FL_WR_NS)),
      .TURN(`TMCPS_CYC(`TMCPS_FL_TA_NS)),
      .HOLD(`TMCPS_CYC(`TMCPS_FL_HOLD_NS)),
      .LAT(`TMCPS_BRIDGE_LAT)
   ) u_fl_ctl (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .s_addr_i(mst_addr_i[FAW-1:0]),
      .s_read_i(mst_read_i && sel_fl),
      .s_write_i(mst_write_i && sel_fl),
      .s_wdata_i(mst_wdata_i[FDW-1:0]),
      .s_waitreq_o(fl_wait),
      .s_rdata_o(fl_rdata),
      .c_req_o(fl_req),
      .c_grant_i(own_q[0]),
      .c_addr_o(fl_addr),
      .c_wdata_o(fl_wdata),
      .c_drive_o(fl_drv),
      .c_rd_o(fl_rd),
      .c_we_o(fl_we),
      .c_cs_o(fl_cs),
      .c_rdata_i(rdata_q[FDW-1:0])
   );

   // SRAM controller, 32-bit words
   tmcps_gen_ctl #(
      .AW(SAW),
      .DW(SDW),
      .RD_WAIT(`TMCPS_CYC(`TMCPS_SR_RD_NS)),
      .WR_WAIT(`TMCPS_CYC(`TMCPS_SR_WR_NS)),
      .TURN(`TMCPS_CYC(`TMCPS_SR_TA_NS)),
      .HOLD(`TMCPS_CYC(`TMCPS_SR_HOLD_NS)),
      .LAT(`TMCPS_BRIDGE_LAT)
   ) u_sr_ctl (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .s_addr_i(sr_off[SAW-1:0]),
      .s_read_i(mst_read_i && sel_sr),
      .s_write_i(mst_write_i && sel_sr),
      .s_wdata_i(mst_wdata_i[SDW-1:0]),
      .s_waitreq_o(sr_wait),
      .s_rdata_o(sr_rdata),
      .c_req_o(sr_req),
      .c_grant_i(own_q[1]),
      .c_addr_o(sr_addr),
      .c_wdata_o(sr_wdata),
      .c_drive_o(sr_drv),
      .c_rd_o(sr_rd),
      .c_we_o(sr_we),
      .c_cs_o(sr_cs),
      .c_rdata_i(rdata_q[SDW-1:0])
   );

   // Narrow shared signals zero-filled above their width
   assign fl_addr_x = {{(PAW-FAW){1'b0}}, fl_addr};
   assign sr_addr_x = {{(PAW-SAW){1'b0}}, sr_addr};
   assign fl_wdata_x = {{(PDW-FDW){1'b0}}, fl_wdata};
   assign sr_wdata_x = {{(PDW-SDW){1'b0}}, sr_wdata};

   // Round-robin: owner keeps pins while requesting
   always @*
   begin
      own_d = 2'b00;
      if (own_q[0] && fl_req)
         own_d = 2'b01;
      else if (own_q[1] && sr_req)
         own_d = 2'b10;
      else if (fl_req && sr_req)
         own_d = last_sr_q ? 2'b01 : 2'b10;
      else if (fl_req)
         own_d = 2'b01;
      else if (sr_req)
         own_d = 2'b10;
   end

   // Owner flop; remembers last SRAM grant

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         own_q <= 2'b00;
         last_sr_q <= 1'b0;
      end
      else
      begin
         own_q <= own_d;
         if (own_d[1] && !own_q[1])
            last_sr_q <= 1'b1;
         else if (own_d[0] && !own_q[0])
            last_sr_q <= 1'b0;
      end
   end

   // Bridge: every pin registered both ways
   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         addr_q <= {PAW{1'b0}};
         wdata_q <= {PDW{1'b0}};
         rdata_q <= {PDW{1'b0}};
         drv_q <= 1'b0;
         rd_q <= 1'b0;
         we_q <= 1'b0;
         fl_cs_q <= 1'b0;
         sr_cs_q <= 1'b0;
         ctl_oe_n_q <= 1'b1;
      end
      else
      begin
         ctl_oe_n_q <= 1'b0;
         rdata_q <= pin_data_i;
         // Selects bypass the grant
         fl_cs_q <= fl_cs;
         sr_cs_q <= sr_cs;
         case (own_q)
            2'b01:
            begin
               addr_q <= fl_addr_x;
               wdata_q <= fl_wdata_x;
               drv_q <= fl_drv;
               rd_q <= fl_rd;
               we_q <= fl_we;
            end
            2'b10:
            begin
               addr_q <= sr_addr_x;
               wdata_q <= sr_wdata_x;
               drv_q <= sr_drv;
               rd_q <= sr_rd;
               we_q <= sr_we;
            end
            default:
            begin
               addr_q <= {PAW{1'b0}};
               wdata_q <= {PDW{1'b0}};
               drv_q <= 1'b0;
               rd_q <= 1'b0;
               we_q <= 1'b0;
            end
         endcase
      end
   end

   // Pads: selects and strobes active low
   assign pin_addr_o = addr_q;
   assign pin_ctl_oe_n_o = ctl_oe_n_q;
   assign pin_data_o = wdata_q;
   assign pin_data_oe_n_o = ~drv_q;
   assign pin_rd_n_o = ~rd_q;
   assign pin_we_n_o = ~we_q;
   assign pin_fl_cs_n_o = ~fl_cs_q;
   assign pin_sr_cs_n_o = ~sr_cs_q;
endmodule // tmcps_top

// File: tmcps_top_sva.sv
`timescale 1ns/1ns
module tmcps_top_sva #(
   parameter MAW = 24,
   parameter PAW = 23,
   parameter PDW = 32
)(
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire [MAW-1:0] mst_addr_i,
   input wire mst_read_i,
   input wire mst_write_i,
   input wire mst_waitreq_o,
   input wire mst_err_o,
   input wire [PAW-1:0] pin_addr_o,
   input wire pin_ctl_oe_n_o,
   input wire [PDW-1:0] pin_data_o,
   input wire pin_data_oe_n_o,
   input wire pin_rd_n_o,
   input wire pin_we_n_o,
   input wire pin_fl_cs_n_o,
   input wire pin_sr_cs_n_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   wire req_w = mst_read_i || mst_write_i;
   property p_oe_on; $past(arst_n_i) |-> !pin_ctl_oe_n_o; endproperty
   property p_cs_one; !(!pin_fl_cs_n_o && !pin_sr_cs_n_o); endproperty
   property p_unmap;
      req_w && mst_addr_i >= 24'hA00000 |-> mst_err_o && !mst_waitreq_o;
   endproperty
   property p_fl_hi;
      !pin_fl_cs_n_o && !pin_data_oe_n_o |-> pin_data_o[PDW-1:16] == 0;
   endproperty
   property p_sr_hi; !pin_sr_cs_n_o |-> pin_addr_o[PAW-1:21] == 0; endproperty
   property p_wr_drv; !pin_we_n_o |-> !pin_data_oe_n_o; endproperty
   property p_rd_rel; !pin_rd_n_o |-> pin_data_oe_n_o; endproperty
   property p_fl_rd;
      $rose(mst_read_i) && mst_addr_i < 24'h800000
         |-> mst_waitreq_o [*8] ##[1:20] !mst_waitreq_o;
   endproperty
   property p_wait_one;
      $fell(mst_waitreq_o) && !mst_err_o |=> mst_waitreq_o || mst_err_o;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("pins not enabled");
   a_cs_one: assert property (p_cs_one) else $error("two selects");
   a_unmap: assert property (p_unmap) else $error("no error answer");
   a_fl_hi: assert property (p_fl_hi) else $error("data high bits");
   a_sr_hi: assert property (p_sr_hi) else $error("addr high bits");
   a_wr_drv: assert property (p_wr_drv) else $error("write undriven");
   a_rd_rel: assert property (p_rd_rel) else $error("read driven");
   a_fl_rd: assert property (p_fl_rd) else $error("read timing");
   a_wait_one: assert property (p_wait_one) else $error("wait low long");
   c_err: cover property (mst_err_o);
   c_fl_rd: cover property (!pin_fl_cs_n_o && !pin_rd_n_o);
   c_sr_wr: cover property (!pin_sr_cs_n_o && !pin_we_n_o);
endmodule // tmcps_top_sva
bind tmcps_top tmcps_top_sva #(.MAW(MAW), .PAW(PAW), .PDW(PDW)) u_sva (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .mst_addr_i(mst_addr_i),
   .mst_read_i(mst_read_i), .mst_write_i(mst_write_i),
   .mst_waitreq_o(mst_waitreq_o), .mst_err_o(mst_err_o),
   .pin_addr_o(pin_addr_o), .pin_ctl_oe_n_o(pin_ctl_oe_n_o),
   .pin_data_o(pin_data_o), .pin_data_oe_n_o(pin_data_oe_n_o),
   .pin_rd_n_o(pin_rd_n_o), .pin_we_n_o(pin_we_n_o),
   .pin_fl_cs_n_o(pin_fl_cs_n_o), .pin_sr_cs_n_o(pin_sr_cs_n_o));

// File: tmcps_mem_model.sv
`timescale 1ns/1ns
module tmcps_mem_model (
   input wire clk_sys_i,
   input wire ctl_oe_n_i,
   input wire [22:0] addr_i,
   input wire [31:0] data_i,
   input wire data_oe_n_i,
   input wire rd_n_i,
   input wire we_n_i,
   input wire fl_cs_n_i,
   input wire sr_cs_n_i,
   output wire [31:0] data_o
);
   logic [15:0] fl [int];
   logic [31:0] sr [int];
   logic [31:0] last_q = 32'h0;
   logic [31:0] rd_v;
   wire on_w = !ctl_oe_n_i;
   always @(posedge clk_sys_i)
   begin
      if (on_w && !we_n_i && !fl_cs_n_i) fl[addr_i[22:1]] = data_i[15:0];
      if (on_w && !we_n_i && !sr_cs_n_i) sr[addr_i[20:2]] = data_i;
      last_q <= data_o;
   end
   // Released bus shows inverted last value
   always @(negedge clk_sys_i or addr_i or rd_n_i or fl_cs_n_i or sr_cs_n_i
      or ctl_oe_n_i)
      if (!on_w || rd_n_i)
         rd_v = ~last_q;
      else if (!fl_cs_n_i)
         rd_v = {~last_q[31:16], fl.exists(addr_i[22:1]) ? fl[addr_i[22:1]]
            : 16'h0000};
      else if (!sr_cs_n_i)
         rd_v = sr.exists(addr_i[20:2]) ? sr[addr_i[20:2]] : 32'h0;
      else
         rd_v = ~last_q;
   assign data_o = !data_oe_n_i ? data_i : rd_v;
endmodule // tmcps_mem_model

// File: tmcps_tb.sv
`timescale 1ns/1ns
module tb;
   logic clk_sys_i, arst_n_i, mst_read_i, mst_write_i, e;
   logic [23:0] mst_addr_i;
   logic [31:0] mst_wdata_i, mst_rdata_o, pin_data_o, pin_data_i, q, d;
   logic mst_waitreq_o, mst_err_o, pin_ctl_oe_n_o, pin_data_oe_n_o;
   logic pin_rd_n_o, pin_we_n_o, pin_fl_cs_n_o, pin_sr_cs_n_o;
   logic [22:0] pin_addr_o;
   logic [23:0] al[$];
   logic [31:0] ref_m [int];
   int err_count = 0;
   int n_checks = 0;
   tmcps_top DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .mst_addr_i(mst_addr_i), .mst_read_i(mst_read_i),
      .mst_write_i(mst_write_i), .mst_wdata_i(mst_wdata_i),
      .mst_waitreq_o(mst_waitreq_o), .mst_rdata_o(mst_rdata_o),
      .mst_err_o(mst_err_o), .pin_addr_o(pin_addr_o),
      .pin_ctl_oe_n_o(pin_ctl_oe_n_o), .pin_data_o(pin_data_o),
      .pin_data_oe_n_o(pin_data_oe_n_o), .pin_data_i(pin_data_i),
      .pin_rd_n_o(pin_rd_n_o), .pin_we_n_o(pin_we_n_o),
      .pin_fl_cs_n_o(pin_fl_cs_n_o), .pin_sr_cs_n_o(pin_sr_cs_n_o));
   tmcps_mem_model u_mem (.clk_sys_i(clk_sys_i), .ctl_oe_n_i(pin_ctl_oe_n_o),
      .addr_i(pin_addr_o), .data_i(pin_data_o), .data_oe_n_i(pin_data_oe_n_o),
      .rd_n_i(pin_rd_n_o), .we_n_i(pin_we_n_o), .fl_cs_n_i(pin_fl_cs_n_o),
      .sr_cs_n_i(pin_sr_cs_n_o), .data_o(pin_data_i));
   initial
   begin
      clk_sys_i = 0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x)
      begin
         err_count++;
         $display("unexpected at %0t ns: got %h exp %h", $time, g, x);
      end
   endtask
   // Word key: flash 16-bit words, sram 32-bit words
   function automatic int key(input logic [23:0] x);
      return x[23] ? {x[23:2], 2'b00} : {x[23:1], 1'b0};
   endfunction
   function automatic logic [31:0] expv(input logic [23:0] x);
      return ref_m.exists(key(x)) ? ref_m[key(x)] : 32'h0;
   endfunction
   // Entered at a falling edge, holds request until wait released
   task automatic acc(input logic wr, input logic [23:0] a,
      input logic [31:0] dv, output logic [31:0] qo, output logic eo);
      int n;
      n = 0;
      mst_addr_i = a;
      mst_write_i = wr;
      mst_read_i = !wr;
      mst_wdata_i = dv;
      #1;
      while (mst_waitreq_o !== 1'b0 && n < 200)
      begin
         @(negedge clk_sys_i);
         #1;
         n++;
      end
      if (n >= 200)
         chk(32'h0, 32'h1);
      qo = mst_rdata_o;
      eo = mst_err_o;
      @(negedge clk_sys_i);
   endtask
   initial
   begin
      #500000;
      err_count++;
      $display("watchdog expired");
      test_done;
   end
   initial
   begin
      arst_n_i = 0;
      mst_addr_i = 24'h0;
      mst_read_i = 0;
      mst_write_i = 0;
      mst_wdata_i = 32'h0;
      q = $urandom(32'hCCD7);
      repeat (5) @(negedge clk_sys_i);
      chk(pin_ctl_oe_n_o, 32'h1);
      arst_n_i = 1;
      @(negedge clk_sys_i);
      chk(pin_ctl_oe_n_o, 32'h0);
      $display("test reset done");
      al = '{24'h000000, 24'h7FFFFF, 24'h800000, 24'h9FFFFF};
      repeat (8) al.push_back($urandom_range(24'h7FFFFF));
      repeat (8) al.push_back(24'h800000 + $urandom_range(24'h1FFFFF));
      foreach (al[i])
      begin
         d = $urandom;
         acc(1'b1, al[i], d, q, e);
         ref_m[key(al[i])] = al[i][23] ? d : {16'h0000, d[15:0]};
      end
      $display("test write done");
      foreach (al[i])
      begin
         acc(1'b0, al[i], 32'h0, q, e);
         chk(q, expv(al[i]));
      end
      acc(1'b0, 24'h000102, 32'h0, q, e);
      chk(q, expv(24'h000102));
      $display("test read done");
      foreach (al[i])
      begin
         acc(i[0], 24'hA00000 + {2'b00, al[i][21:0]}, 32'h0, q, e);
         chk(e, 32'h1);
      end
      mst_read_i = 0;
      mst_write_i = 0;
      $display("test unmapped done");
      @(negedge clk_sys_i);
      arst_n_i = 0;
      @(negedge clk_sys_i);
      chk(pin_ctl_oe_n_o, 32'h1);
      chk(pin_data_oe_n_o, 32'h1);
      arst_n_i = 1;
      @(negedge clk_sys_i);
      chk(pin_ctl_oe_n_o, 32'h0);
      acc(1'b0, al[2], 32'h0, q, e);
      chk(q, expv(al[2]));
      mst_read_i = 0;
      $display("test second reset done");
      test_done;
   end
endmodule // tb
